// File: common/crio_pkg.sv
/*
 * Shared constants for the CPU register set and its memory-mapped cells:
 * bus widths, the small memory map, reset values, flag layout, commands.
 * Assumes a single processor clock; no timing constants are needed.
 */
package crio_pkg;

    localparam int ADDR_W    = 13;
    localparam int DATA_W    = 8;
    localparam int PCVIEW_W  = 16;
    localparam int RAM_IDX_W = 7;
    localparam int RAM_DEPTH = 128;

    ////////////////////////////////////////////////////////////////////////////
    // Memory map
    localparam logic [12:0] OUT_PORT_ADDR = 13'h0000;
    localparam logic [12:0] IN_PORT_ADDR  = 13'h0001;
    localparam logic [12:0] RAM_BASE      = 13'h0080;
    localparam logic [12:0] RAM_END       = 13'h0100;
    localparam logic [12:0] VEC_HI_ADDR   = 13'h1ffe;
    localparam logic [12:0] VEC_LO_ADDR   = 13'h1fff;
    localparam logic [12:0] DEF_RESET_VEC = 13'h0100;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and fixed fields
    localparam logic [7:0] SP_RESET     = 8'hff;
    localparam logic [7:0] BYTE_ZERO    = 8'h00;
    localparam logic [7:0] BYTE_ONE     = 8'h01;
    localparam logic [2:0] FLAGS_UNUSED = 3'h7;
    localparam logic [2:0] PC_PAD       = 3'h0;
    localparam logic [4:0] FLAGS_RESET  = 5'h08;
    localparam logic [4:0] ADDR_HI_PAD  = 5'h00;

    // Live flag positions inside the low five bits
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_I = 3;
    localparam int FLAG_H = 4;

    typedef enum logic [3:0] {
        OP_NOP,
        OP_LDA_IMM,
        OP_LDX_IMM,
        OP_LDA_MEM,
        OP_STA_MEM,
        OP_LDA_IDX,
        OP_STA_IDX,
        OP_ADD_IMM,
        OP_SET_FLAGS,
        OP_JUMP,
        OP_ADVANCE,
        OP_PUSH,
        OP_PULL,
        OP_STACK_REINIT
    } crio_op_t;

    typedef enum logic [1:0] {
        ST_FETCH_HI,
        ST_FETCH_LO,
        ST_RUN
    } crio_state_t;

endpackage

// File: verilog/crio_port_byte.sv
/*
 * One byte of simple I/O: an input port with pin synchronisers and an
 * output port latch with readback, repeated per bit by a generate loop.
 * Assumes pins are asynchronous to clk; the latch is written by the owner.
 */
`timescale 1ns/1ps

module crio_port_byte #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         out_wr,
    input  wire logic [W-1:0] wdata,
    input  wire logic [W-1:0] pin_in,
    input  wire logic         sel_in,
    input  wire logic         sel_out,
    output logic      [W-1:0] out_latch,
    output logic      [W-1:0] rd_data
);
    import crio_pkg::*;

    logic [W-1:0] in_meta_reg;
    logic [W-1:0] in_sync_reg;

    for (genvar b = 0; b < W; b++) begin : g_bit
        // Second flop alone feeds the read path
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                in_meta_reg[b] <= 1'b0;
                in_sync_reg[b] <= 1'b0;
            end else begin
                in_meta_reg[b] <= pin_in[b];
                in_sync_reg[b] <= in_meta_reg[b];
            end
        end

        // Latch reset to low so pins never float at power-up
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                out_latch[b] <= 1'b0;
            end else if (out_wr) begin
                out_latch[b] <= wdata[b];
            end
        end

        // Readback shows the latch, never the pin
        assign rd_data[b] = (sel_in  & in_sync_reg[b])
                          | (sel_out & out_latch[b]);
    end

endmodule

// File: verilog/crio_cpu_regs.sv
/*
 * Programmer-visible register set of a small 8-bit CPU plus the memory
 * cells it reaches over a 13-bit address and 8-bit data bus: RAM bytes,
 * one input port and one output port with readback, and a reset vector.
 * Assumes the sequencer issues one command per cycle on cmd_valid.
 */
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps

module crio_cpu_regs #(
    parameter logic [12:0] RESET_VECTOR = crio_pkg::DEF_RESET_VEC
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              cmd_valid,
    input  wire crio_pkg::crio_op_t cmd_op,
    input  wire logic [7:0]        cmd_data,
    input  wire logic [12:0]       cmd_addr,
    input  wire logic [7:0]        in_pins,
    output logic      [7:0]        out_pins,
    output logic                   ready,
    output logic      [7:0]        acc_q,
    output logic      [7:0]        ptr_q,
    output logic      [15:0]       pc_view,
    output logic      [7:0]        flags_q,
    output logic      [7:0]        sp_q,
    output logic      [12:0]       addr_bus,
    output logic      [7:0]        data_bus,
    output logic                   bus_wr,
    output logic                   bus_rd
);
    import crio_pkg::*;

    function automatic logic is_ram(input logic [12:0] a);
        return (a >= RAM_BASE) && (a < RAM_END);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset release aligned to clk
    logic rst_meta_reg;
    logic rst_int_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_int_n    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_int_n    <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State
    crio_state_t state_reg;
    crio_state_t state_next;
    logic [7:0]  acc_reg;
    logic [7:0]  ptr_reg;
    logic [12:0] pc_reg;
    logic [4:0]  flags_reg;
    logic [7:0]  sp_reg;
    logic [7:0]  vec_hi_reg;
    logic        ready_reg;
    logic [7:0]  ram_mem [RAM_DEPTH];
    logic [12:0] addr_bus_reg;
    logic [7:0]  data_bus_reg;
    logic        bus_wr_reg;
    logic        bus_rd_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    wire run_cmd   = (state_reg == ST_RUN) && cmd_valid;
    wire op_push   = run_cmd && (cmd_op == OP_PUSH);
    wire op_pull   = run_cmd && (cmd_op == OP_PULL);
    wire op_idx    = run_cmd && ((cmd_op == OP_LDA_IDX) || (cmd_op == OP_STA_IDX));
    wire op_direct = run_cmd && ((cmd_op == OP_LDA_MEM) || (cmd_op == OP_STA_MEM));
    wire op_read   = run_cmd && ((cmd_op == OP_LDA_MEM) || (cmd_op == OP_LDA_IDX));
    wire op_store  = run_cmd && ((cmd_op == OP_STA_MEM) || (cmd_op == OP_STA_IDX));
    wire fetching  = (state_reg != ST_RUN);

    wire [7:0]  sp_inc = 8'(sp_reg + BYTE_ONE);
    wire [7:0]  sp_dec = 8'(sp_reg - BYTE_ONE);

    // Effective address; registers themselves never decode here
    wire [12:0] ea = (state_reg == ST_FETCH_HI) ? VEC_HI_ADDR :
                     (state_reg == ST_FETCH_LO) ? VEC_LO_ADDR :
                     op_push                    ? {ADDR_HI_PAD, sp_reg} :
                     op_pull                    ? {ADDR_HI_PAD, sp_inc} :
                     op_idx                     ? {ADDR_HI_PAD, ptr_reg} :
                     op_direct                  ? cmd_addr :
                                                  RAM_BASE;

    wire mem_wr = op_store || op_push;
    wire mem_rd = fetching || op_read || op_pull;

    // Same decode for every kind of location
    wire sel_ram = is_ram(ea);
    wire sel_in  = (ea == IN_PORT_ADDR);
    wire sel_out = (ea == OUT_PORT_ADDR);
    wire [RAM_IDX_W-1:0] ram_idx = RAM_IDX_W'(ea - RAM_BASE);
    wire [7:0] wr_byte = acc_reg;

    ////////////////////////////////////////////////////////////////////////////
    // I/O byte
    logic [7:0] port_rd;

    crio_port_byte #(
        .W (DATA_W)
    ) u_port (
        .clk       (clk),
        .rst_n     (rst_int_n),
        .out_wr    (mem_wr && sel_out),
        .wdata     (wr_byte),
        .pin_in    (in_pins),
        .sel_in    (sel_in),
        .sel_out   (sel_out),
        .out_latch (out_pins),
        .rd_data   (port_rd)
    );

    // Read mux settles within the access cycle
    wire [7:0] ram_rd = sel_ram ? ram_mem[ram_idx] : BYTE_ZERO;
    wire [7:0] vec_rd = (ea == VEC_HI_ADDR) ? {PC_PAD, RESET_VECTOR[12:8]} :
                        (ea == VEC_LO_ADDR) ? RESET_VECTOR[7:0] : BYTE_ZERO;
    wire [7:0] rd_byte = ram_rd | port_rd | vec_rd;

    // Left without reset: contents are undefined until software writes them
    always_ff @(posedge clk) begin
        if (mem_wr && sel_ram) begin
            ram_mem[ram_idx] <= wr_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic and flags
    wire [8:0] sum     = {1'b0, acc_reg} + {1'b0, cmd_data};
    wire [4:0] low_sum = {1'b0, acc_reg[3:0]} + {1'b0, cmd_data[3:0]};
    wire [7:0] load_val = (cmd_op == OP_LDA_IMM) ? cmd_data :
                          (cmd_op == OP_ADD_IMM) ? sum[7:0] : rd_byte;
    wire loads_acc = run_cmd && ((cmd_op == OP_LDA_IMM) || (cmd_op == OP_ADD_IMM)
                                 || op_read || op_pull);

    logic [4:0] flags_next;
    always_comb begin
        flags_next = flags_reg;
        if (run_cmd && (cmd_op == OP_SET_FLAGS)) begin
            flags_next = cmd_data[4:0];
        end else if (loads_acc) begin
            flags_next[FLAG_Z] = (load_val == BYTE_ZERO);
            flags_next[FLAG_N] = load_val[7];
            if (cmd_op == OP_ADD_IMM) begin
                flags_next[FLAG_C] = sum[8];
                flags_next[FLAG_H] = low_sum[4];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: two vector reads, then commands
    always_comb begin
        case (state_reg)
            ST_FETCH_HI: state_next = ST_FETCH_LO;
            ST_FETCH_LO: state_next = ST_RUN;
            default:     state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            state_reg  <= ST_FETCH_HI;
            vec_hi_reg <= BYTE_ZERO;
            ready_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_reg <= (state_next == ST_RUN);
            if (state_reg == ST_FETCH_HI) begin
                vec_hi_reg <= rd_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CPU registers
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            acc_reg   <= BYTE_ZERO;
            ptr_reg   <= BYTE_ZERO;
            flags_reg <= FLAGS_RESET;
        end else begin
            if (loads_acc) begin
                acc_reg <= load_val;
            end
            if (run_cmd && (cmd_op == OP_LDX_IMM)) begin
                ptr_reg <= cmd_data;
            end
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            pc_reg <= RAM_BASE;
        end else if (state_reg == ST_FETCH_LO) begin
            pc_reg <= {vec_hi_reg[4:0], rd_byte};
        end else if (run_cmd && (cmd_op == OP_JUMP)) begin
            pc_reg <= cmd_addr;
        end else if (run_cmd && (cmd_op == OP_ADVANCE)) begin
            pc_reg <= 13'(pc_reg + 13'h0001);
        end
    end

    // Stack may run out of RAM if software nests too deep; no guard here
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            sp_reg <= SP_RESET;
        end else if (run_cmd && (cmd_op == OP_STACK_REINIT)) begin
            sp_reg <= SP_RESET;
        end else if (op_push) begin
            sp_reg <= sp_dec;
        end else if (op_pull) begin
            sp_reg <= sp_inc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus trace: what was driven or returned in the last access
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            addr_bus_reg <= RAM_BASE;
            data_bus_reg <= BYTE_ZERO;
            bus_wr_reg   <= 1'b0;
            bus_rd_reg   <= 1'b0;
        end else begin
            bus_wr_reg <= mem_wr;
            bus_rd_reg <= mem_rd;
            if (mem_wr || mem_rd) begin
                addr_bus_reg <= ea;
                data_bus_reg <= mem_wr ? wr_byte : rd_byte;
            end
        end
    end

    assign acc_q    = acc_reg;
    assign ptr_q    = ptr_reg;
    assign pc_view  = {PC_PAD, pc_reg};
    assign flags_q  = {FLAGS_UNUSED, flags_reg};
    assign sp_q     = sp_reg;
    assign ready    = ready_reg;
    assign addr_bus = addr_bus_reg;
    assign data_bus = data_bus_reg;
    assign bus_wr   = bus_wr_reg;
    assign bus_rd   = bus_rd_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_int_n);

    property p_push;
        op_push |=> (addr_bus == {ADDR_HI_PAD, $past(sp_reg)}) && bus_wr
                    && (sp_reg == 8'($past(sp_reg) - BYTE_ONE));
    endproperty
    a_push: assert property (p_push) else $error("push order wrong");

    property p_pull;
        op_pull |=> (sp_reg == 8'($past(sp_reg) + BYTE_ONE))
                    && (addr_bus == {ADDR_HI_PAD, sp_reg}) && (acc_reg == data_bus);
    endproperty
    a_pull: assert property (p_pull) else $error("pull order wrong");

    property p_reinit;
        run_cmd && (cmd_op == OP_STACK_REINIT) |=> sp_reg == SP_RESET;
    endproperty
    a_reinit: assert property (p_reinit) else $error("stack reinit failed");

    property p_vector;
        $rose(ready) |-> pc_reg == RESET_VECTOR;
    endproperty
    a_vector: assert property (p_vector) else $error("reset vector not loaded");

    property p_advance;
        run_cmd && (cmd_op == OP_ADVANCE) |=> pc_view == {PC_PAD, 13'($past(pc_reg) + 13'h0001)};
    endproperty
    a_advance: assert property (p_advance) else $error("counter did not advance");

    property p_pc_top;
        pc_view[15:13] == PC_PAD;
    endproperty
    a_pc_top: assert property (p_pc_top) else $error("counter top bits set");

    property p_flags_top;
        flags_q[7:5] == FLAGS_UNUSED;
    endproperty
    a_flags_top: assert property (p_flags_top) else $error("flag top bits not one");

    property p_in_write;
        op_store && (ea == IN_PORT_ADDR) |=> $stable(out_pins);
    endproperty
    a_in_write: assert property (p_in_write) else $error("input port write had effect");

    property p_out_write;
        op_store && (ea == OUT_PORT_ADDR) |=> out_pins == $past(acc_reg);
    endproperty
    a_out_write: assert property (p_out_write) else $error("output latch missed write");

    property p_readback;
        op_read && (ea == OUT_PORT_ADDR) |=> acc_reg == $past(out_pins);
    endproperty
    a_readback: assert property (p_readback) else $error("readback not latch value");

    property p_ram_hold;
        op_store && sel_ram ##1 op_read && (ea == $past(ea)) |=> acc_reg == $past(acc_reg, 2);
    endproperty
    a_ram_hold: assert property (p_ram_hold) else $error("RAM lost stored byte");

    c_push:  cover property (op_push ##1 op_pull);
    c_ready: cover property ($rose(ready));
    c_out:   cover property (op_store && sel_out);
    c_in:    cover property (op_read && sel_in);
    c_pair:  cover property (op_store && sel_ram ##1 op_read);

endmodule

// File: test/crio_pin_model.sv
/*
 * Pin-side model for the simple I/O of crio_cpu_regs: drives the input
 * port pins as plain levels and stands as the load on the output pins.
 * Assumes the bench changes pin levels through set_pins only.
 */
`timescale 1ns/1ps

module crio_pin_model (
    input  wire logic       clk,
    input  wire logic [7:0] out_pins,
    output logic      [7:0] in_pins
);
    logic [7:0] level_reg;

    // Pins hold a level from time zero, so the synchronisers never see X
    initial level_reg = 8'ha5;

    // The whole byte changes on one edge; no partial-byte glitches
    assign in_pins = level_reg;

    task automatic set_pins(input logic [7:0] v);
        @(posedge clk);
        level_reg <= v;
    endtask
endmodule

// File: test/tb.sv
/*
 * Self-checking bench for crio_cpu_regs: a command task that speaks the
 * command port, and directed sequences with expected values.
 * Assumes crio_pkg is compiled first and crio_pin_model stands at the pins.
 */
`timescale 1ns/1ps

module tb;
    import crio_pkg::*;

    // Non-default vector so that a hard-wired start address shows up
    localparam logic [12:0] VEC = 13'h1abc;

    logic        clk;
    logic        rst_n;
    logic        cmd_valid;
    crio_op_t    cmd_op;
    logic [7:0]  cmd_data;
    logic [12:0] cmd_addr;
    logic [7:0]  in_pins;
    logic [7:0]  out_pins;
    logic        ready;
    logic [7:0]  acc_q;
    logic [7:0]  ptr_q;
    logic [15:0] pc_view;
    logic [7:0]  flags_q;
    logic [7:0]  sp_q;
    logic [12:0] addr_bus;
    logic [7:0]  data_bus;
    logic        bus_wr;
    logic        bus_rd;
    int          err_count;
    int          n_compared;
    logic [7:0]  stk [2];

    crio_cpu_regs #(.RESET_VECTOR(VEC)) dut (
        .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .cmd_addr(cmd_addr), .in_pins(in_pins),
        .out_pins(out_pins), .ready(ready), .acc_q(acc_q), .ptr_q(ptr_q),
        .pc_view(pc_view), .flags_q(flags_q), .sp_q(sp_q), .addr_bus(addr_bus),
        .data_bus(data_bus), .bus_wr(bus_wr), .bus_rd(bus_rd)
    );

    crio_pin_model pm (.clk(clk), .out_pins(out_pins), .in_pins(in_pins));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Valid drops for a cycle after each command so no signal is driven twice
    task automatic cmd(input crio_op_t op, input logic [7:0] d, input logic [12:0] a);
        @(posedge clk);
        cmd_valid <= 1'h1;
        cmd_op    <= op;
        cmd_data  <= d;
        cmd_addr  <= a;
        @(posedge clk);
        cmd_valid <= 1'h0;
        #1;
    endtask

    // Back-to-back commands: valid stays high, only the code changes
    task automatic cmd_pair(input crio_op_t op1, input crio_op_t op2, input logic [12:0] a);
        @(posedge clk);
        cmd_valid <= 1'h1;
        cmd_op    <= op1;
        cmd_data  <= 8'h00;
        cmd_addr  <= a;
        @(posedge clk);
        cmd_op    <= op2;
        @(posedge clk);
        cmd_valid <= 1'h0;
        #1;
    endtask

    task automatic do_reset();
        int i;
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (8) @(posedge clk);
        #1;
        check(16'(sp_q), 16'(SP_RESET));
        check(16'(flags_q), 16'h00e8);
        check(16'(pc_view[15:13]), 16'h0000);
        check(16'(out_pins), 16'h0000);
        @(posedge clk);
        rst_n <= 1'h1;
        i = 0;
        while (ready !== 1'h1 && i < 50) begin
            @(posedge clk);
            #1;
            i++;
        end
        check(16'(i), 16'h0004);
        check(pc_view, {3'h0, VEC});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    initial begin
        #50000;
        err_count++;
        end_sim();
    end

    initial begin
        rst_n      = 1'h0;
        cmd_valid  = 1'h0;
        cmd_op     = OP_NOP;
        cmd_data   = 8'h00;
        cmd_addr   = 13'h0000;
        err_count  = 0;
        n_compared = 0;
        stk[0]     = 8'hc3;
        stk[1]     = 8'h11;
        do_reset();
        cmd(OP_LDA_IMM, 8'h5a, 13'h0000);
        check(16'(acc_q), 16'h005a);
        cmd(OP_LDX_IMM, 8'h90, 13'h0000);
        check(16'(ptr_q), 16'h0090);
        cmd(OP_STA_MEM, 8'h00, 13'h0085);
        check({bus_wr, 2'h0, addr_bus}, 16'h8085);
        check(16'(data_bus), 16'h005a);
        cmd(OP_LDA_IMM, 8'ha6, 13'h0000);
        cmd(OP_STA_IDX, 8'h00, 13'h0000);
        check(16'(addr_bus), 16'h0090);
        cmd(OP_LDA_MEM, 8'h00, 13'h0085);
        check({bus_rd, 7'h00, acc_q}, 16'h805a);
        cmd(OP_LDA_IDX, 8'h00, 13'h0000);
        check(16'(acc_q), 16'h00a6);
        // Registers hold data but no address reaches them
        cmd(OP_LDA_MEM, 8'h00, 13'h0002);
        check(16'(acc_q), 16'h0000);
        // Store and read back on adjacent cycles at a fresh RAM byte
        cmd(OP_LDA_IMM, 8'h3e, 13'h0000);
        cmd_pair(OP_STA_MEM, OP_LDA_MEM, 13'h00c0);
        check({bus_rd, 2'h0, addr_bus}, 16'h80c0);
        check(16'(acc_q), 16'h003e);
        // Two pushes, then two pulls come back in reverse order
        for (int k = 0; k < 2; k++) begin
            cmd(OP_LDA_IMM, stk[k], 13'h0000);
            cmd(OP_PUSH, 8'h00, 13'h0000);
            check({bus_wr, 2'h0, addr_bus}, 16'h80ff - 16'(k));
            check({data_bus, sp_q}, {stk[k], 8'hfe - 8'(k)});
        end
        cmd(OP_LDA_IMM, 8'h00, 13'h0000);
        for (int k = 1; k >= 0; k--) begin
            cmd(OP_PULL, 8'h00, 13'h0000);
            check({bus_rd, 2'h0, addr_bus}, 16'h80ff - 16'(k));
            check({acc_q, sp_q}, {stk[k], 8'hff - 8'(k)});
        end
        check(16'(addr_bus), 16'h00ff);
        cmd(OP_PUSH, 8'h00, 13'h0000);
        cmd(OP_STACK_REINIT, 8'h00, 13'h0000);
        check(16'(sp_q), 16'(SP_RESET));
        // Push then pull on adjacent cycles returns the pushed byte
        cmd(OP_LDA_IMM, 8'h77, 13'h0000);
        cmd_pair(OP_PUSH, OP_PULL, 13'h0000);
        check({bus_rd, 2'h0, addr_bus}, 16'h80ff);
        check({acc_q, sp_q}, 16'h77ff);
        // Output latch, readback and input port
        cmd(OP_LDA_IMM, 8'h96, 13'h0000);
        cmd(OP_STA_MEM, 8'h00, OUT_PORT_ADDR);
        check(16'(out_pins), 16'h0096);
        pm.set_pins(8'h3c);
        repeat (4) @(posedge clk);
        cmd(OP_LDA_MEM, 8'h00, OUT_PORT_ADDR);
        check(16'(acc_q), 16'h0096);
        cmd(OP_LDA_MEM, 8'h00, IN_PORT_ADDR);
        check(16'(acc_q), 16'h003c);
        cmd(OP_LDA_IMM, 8'h55, 13'h0000);
        cmd(OP_STA_MEM, 8'h00, IN_PORT_ADDR);
        cmd(OP_LDA_MEM, 8'h00, IN_PORT_ADDR);
        check({out_pins, acc_q}, 16'h963c);
        // Carry out of both nibbles; I stays set from reset
        cmd(OP_LDA_IMM, 8'hff, 13'h0000);
        cmd(OP_ADD_IMM, 8'h01, 13'h0000);
        check({acc_q, flags_q}, 16'h00fb);
        cmd(OP_SET_FLAGS, 8'h00, 13'h0000);
        check(16'(flags_q), 16'h00e0);
        // Counter wraps within 13 bits; the padding stays zero
        cmd(OP_JUMP, 8'h00, 13'h1fff);
        check(pc_view, 16'h1fff);
        cmd(OP_ADVANCE, 8'h00, 13'h0000);
        check(pc_view, 16'h0000);
        // Reset in mid-run clears the latch and restarts from the vector
        do_reset();
        cmd(OP_LDA_IMM, 8'h01, 13'h0000);
        check(16'(acc_q), 16'h0001);
        end_sim();
    end
endmodule
